// File: acs_clock_ctrl.sv
// Main clock selection, modulator tick and channel front-end control
//
// Contract
// - Each channel has a two-bit source field routing pins, ground, +test or -test.
// - Each channel has its own three-bit gain code for gains 1 through 128.
// - One positive and one negative test level serve all channels via their sources.
// - One configuration bit picks external input or internal oscillator as main clock.
// - After reset the external input is the main clock source.
// - The internal oscillator stays off after reset until software selects it.
// - A two-bit power field picks one of three modes and also scales bias levels.
// - The oscillator path divides by 1, 2 or 4 for the three power modes.
// - The modulator tick falls on every second main clock tick counted from reset or standby.
// - With the external input held low, leaving it for the oscillator needs no standby.
// - Conversion is held off until the reference has settled after start-up.
`timescale 1ns/1ps
`default_nettype none
module acs_clock_ctrl #(
   parameter int NUM_CH  = acs_pkg::NUM_CH,
   parameter int REF_CYC = acs_pkg::REF_SETTLE_CYC
) (
   input  wire  logic                    sys_clk,
   input  wire  logic                    reset_n,
   input  wire  logic                    wb_cyc_i,
   input  wire  logic                    wb_stb_i,
   input  wire  logic                    wb_we_i,
   input  wire  logic [7:0]              wb_adr_i,
   input  wire  logic [3:0]              wb_sel_i,
   input  wire  logic [31:0]             wb_dat_i,
   output logic       [31:0]             wb_dat_o,
   output logic                          wb_ack_o,
   input  wire  logic                    external_clock_input,
   output logic                          osc_enable,
   output logic                          mclk_tick,
   output logic                          mod_tick,
   output logic                          conv_enable,
   output acs_pkg::acs_pwr_t             bias_level,
   output logic       [NUM_CH*4-1:0]     channel_route,
   output logic       [NUM_CH*3-1:0]     channel_gain_code,
   output logic                          test_pos_enable,
   output logic                          test_neg_enable
);
   import acs_pkg::*;

   localparam int REF_W = $clog2(REF_CYC + 1);

   // ==========================================================
   // Register state
   logic               clk_sel;
   logic               next_clk_sel;
   acs_pwr_t           power_mode_select;
   acs_pwr_t           next_pwr;
   logic               standby;
   logic               next_standby;
   acs_mux_t           ch_mux      [NUM_CH];
   acs_mux_t           next_ch_mux [NUM_CH];
   acs_gain_t          ch_gain     [NUM_CH];
   acs_gain_t          next_ch_gain[NUM_CH];
   logic               unsafe_sw;
   logic               next_unsafe_sw;
   logic               ack;
   logic               next_ack;
   logic [31:0]        rdata;
   logic [31:0]        next_rdata;
   logic [31:0]        rd;
   logic               req;
   logic               wr;

   // Clock state
   logic               ext_meta;
   logic               ext_sync;
   logic               ext_prev;
   logic               ext_seen;
   logic               next_ext_seen;
   logic               ext_edge;
   logic [REF_W-1:0]   ref_cnt;
   logic [REF_W-1:0]   next_ref_cnt;
   logic               ref_ready;
   logic               next_ref_ready;
   logic               next_mclk;
   logic               next_conv;
   logic               osc_q;
   acs_pwr_t           next_bias;
   logic [NUM_CH*4-1:0] next_route;
   logic [NUM_CH*3-1:0] next_gain;
   logic               next_tpos;
   logic               next_tneg;

   acs_clk_if clk ();

   acs_osc_div u_osc (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .bus     (clk.osc)
   );

   acs_mod_div u_mod (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .bus     (clk.modg)
   );

   // ==========================================================
   // Wishbone slave and registers
   always_comb begin
      req            = wb_cyc_i & wb_stb_i;
      wr             = req & wb_we_i & ack & wb_sel_i[0];
      next_ack       = req & ~ack;
      next_clk_sel   = clk_sel;
      next_pwr       = power_mode_select;
      next_standby   = standby;
      next_ch_mux    = ch_mux;
      next_ch_gain   = ch_gain;
      next_unsafe_sw = unsafe_sw;
      rd             = 32'h0;
      unique case (wb_adr_i)
         ADDR_CLOCK: begin
            rd[CLK_SEL_BIT]      = clk_sel;
            rd[PWR_LSB +: 2]     = power_mode_select;
            rd[STANDBY_BIT]      = standby;
         end
         ADDR_GAIN: begin
            for (int i = 0; i < NUM_CH; i++) begin
               rd[i*GAIN_STRIDE +: 3] = ch_gain[i];
            end
         end
         ADDR_STATUS: begin
            rd[ST_REF_BIT]    = ref_ready;
            rd[ST_OSC_BIT]    = osc_q;
            rd[ST_SEEN_BIT]   = ext_seen;
            rd[ST_UNSAFE_BIT] = unsafe_sw;
         end
         default: begin
            for (int i = 0; i < NUM_CH; i++) begin
               if (wb_adr_i == 8'(ADDR_CH_CFG0 + CH_CFG_STEP * i)) begin
                  rd[MUX_LSB +: 2] = ch_mux[i];
               end
            end
         end
      endcase
      next_rdata = (req & ~ack) ? rd : rdata;
      if (wr && wb_adr_i == ADDR_CLOCK) begin
         next_clk_sel = wb_dat_i[CLK_SEL_BIT];
         next_pwr     = wb_dat_i[PWR_LSB +: 2];
         next_standby = wb_dat_i[STANDBY_BIT];
      end
      for (int i = 0; i < NUM_CH; i++) begin
         if (wr && wb_adr_i == 8'(ADDR_CH_CFG0 + CH_CFG_STEP * i)) begin
            next_ch_mux[i] = wb_dat_i[MUX_LSB +: 2];
         end
         if (wr && wb_adr_i == ADDR_GAIN) begin
            next_ch_gain[i] = wb_dat_i[i*GAIN_STRIDE +: 3];
         end
      end
      if (wr && wb_adr_i == ADDR_STATUS && wb_dat_i[ST_UNSAFE_BIT]) begin
         next_unsafe_sw = 1'b0;
      end
      // flag any select or power change outside standby once the input has been seen high
      if (wr && wb_adr_i == ADDR_CLOCK && !standby && ext_seen
          && (wb_dat_i[CLK_SEL_BIT] != clk_sel
              || wb_dat_i[PWR_LSB +: 2] != power_mode_select)) begin
         next_unsafe_sw = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         clk_sel   <= CLK_SEL_RST;
         power_mode_select       <= PWR_RST;
         standby   <= STANDBY_RST;
         unsafe_sw <= 1'b0;
         ack       <= 1'b0;
         rdata     <= 32'h0;
         for (int i = 0; i < NUM_CH; i++) begin
            ch_mux[i]  <= MUX_RST;
            ch_gain[i] <= GAIN_RST;
         end
      end else begin
         clk_sel   <= next_clk_sel;
         power_mode_select       <= next_pwr;
         standby   <= next_standby;
         unsafe_sw <= next_unsafe_sw;
         ack       <= next_ack;
         rdata     <= next_rdata;
         ch_mux    <= next_ch_mux;
         ch_gain   <= next_ch_gain;
      end
   end

   assign wb_ack_o = ack;
   assign wb_dat_o = rdata;

   // ==========================================================
   // Clock selection and front-end outputs
   assign clk.osc_en = clk_sel;
   assign clk.power_mode_select    = power_mode_select;
   assign clk.run    = ~standby;
   assign ext_edge   = ext_sync & ~ext_prev;
   assign clk.mclk_pulse = ~standby & (clk_sel ? clk.osc_mclk_tick : ext_edge);
   assign mod_tick   = clk.mod_tick;

   always_comb begin
      next_ext_seen  = ext_seen | ext_sync;
      next_mclk      = clk.mclk_pulse;
      next_ref_cnt   = (ref_cnt == REF_W'(REF_CYC)) ? ref_cnt : ref_cnt + 1'b1;
      next_ref_ready = (ref_cnt == REF_W'(REF_CYC));
      next_conv      = ref_ready & ~standby;
      // bias follows mode, spare code as minimum power
      next_bias      = (power_mode_select == 2'h3) ? PWR_VLP : power_mode_select;
      next_tpos      = 1'b0;
      next_tneg      = 1'b0;
      for (int i = 0; i < NUM_CH; i++) begin
         next_route[i*4 +: 4] = acs_route(ch_mux[i]);
         next_gain[i*3 +: 3]  = ch_gain[i];
         next_tpos = next_tpos | (ch_mux[i] == MUX_TEST_POS);
         next_tneg = next_tneg | (ch_mux[i] == MUX_TEST_NEG);
      end
   end

   // Stalled input is a limitation: no watchdog, software must keep it live
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         ext_meta          <= 1'b0;
         ext_sync          <= 1'b0;
         ext_prev          <= 1'b0;
         ext_seen          <= 1'b0;
         ref_cnt           <= '0;
         ref_ready         <= 1'b0;
         mclk_tick         <= 1'b0;
         conv_enable       <= 1'b0;
         osc_q             <= 1'b0;
         bias_level        <= PWR_RST;
         channel_route     <= '0;
         channel_gain_code <= '0;
         test_pos_enable   <= 1'b0;
         test_neg_enable   <= 1'b0;
      end else begin
         ext_meta          <= external_clock_input;
         ext_sync          <= ext_meta;
         ext_prev          <= ext_sync;
         ext_seen          <= next_ext_seen;
         ref_cnt           <= next_ref_cnt;
         ref_ready         <= next_ref_ready;
         mclk_tick         <= next_mclk;
         conv_enable       <= next_conv;
         osc_q             <= clk_sel;
         bias_level        <= next_bias;
         channel_route     <= next_route;
         channel_gain_code <= next_gain;
         test_pos_enable   <= next_tpos;
         test_neg_enable   <= next_tneg;
      end
   end

   assign osc_enable = osc_q;

   // ==========================================================
   // Checks
   logic [3:0] route0_exp;
   acs_gain_t  gain0_exp;
   assign route0_exp = acs_route(ch_mux[0]);
   assign gain0_exp  = ch_gain[0];

   property p_ext_default;
      @(posedge sys_clk) $rose(reset_n) |-> !clk_sel ##1 !osc_enable;
   endproperty
   a_ext_default: assert property (p_ext_default)
      else $error("external source not default after reset");

   property p_osc_off;
      @(posedge sys_clk) disable iff (!reset_n)
      !clk_sel && !$past(clk_sel) |-> !osc_enable;
   endproperty
   a_osc_off: assert property (p_osc_off)
      else $error("oscillator on while not selected");

   property p_ext_pass;
      @(posedge sys_clk) disable iff (!reset_n)
      !clk_sel && !standby && ext_edge |=> mclk_tick;
   endproperty
   a_ext_pass: assert property (p_ext_pass)
      else $error("external edge not passed as main tick");

   property p_src_osc;
      @(posedge sys_clk) disable iff (!reset_n)
      mclk_tick && $past(clk_sel) |-> $past(clk.osc_mclk_tick);
   endproperty
   a_src_osc: assert property (p_src_osc)
      else $error("main tick not from oscillator when selected");

   property p_standby_quiet;
      @(posedge sys_clk) disable iff (!reset_n)
      $past(standby) |-> !mclk_tick && !conv_enable;
   endproperty
   a_standby_quiet: assert property (p_standby_quiet)
      else $error("main tick in standby");

   property p_ref_gate;
      @(posedge sys_clk) disable iff (!reset_n)
      conv_enable |-> ref_ready && ref_cnt == REF_W'(REF_CYC);
   endproperty
   a_ref_gate: assert property (p_ref_gate)
      else $error("conversion before reference settled");

   property p_route;
      @(posedge sys_clk) disable iff (!reset_n)
      reset_n |=> channel_route[3:0] == $past(route0_exp);
   endproperty
   a_route: assert property (p_route)
      else $error("channel source route mismatch");

   property p_gain;
      @(posedge sys_clk) disable iff (!reset_n)
      ##1 channel_gain_code[2:0] == $past(gain0_exp);
   endproperty
   a_gain: assert property (p_gain)
      else $error("channel gain code mismatch");

   property p_test_shared;
      @(posedge sys_clk) disable iff (!reset_n)
      test_pos_enable |-> channel_route[MUX_TEST_POS]
                          || channel_route[4 + MUX_TEST_POS];
   endproperty
   a_test_shared: assert property (p_test_shared)
      else $error("positive test level on without a channel");

   property p_bias;
      @(posedge sys_clk) disable iff (!reset_n)
      power_mode_select != 2'h3 |=> bias_level == $past(power_mode_select);
   endproperty
   a_bias: assert property (p_bias)
      else $error("bias level does not follow power mode");

   property p_safe_low;
      @(posedge sys_clk) disable iff (!reset_n)
      !ext_seen |=> !unsafe_sw;
   endproperty
   a_safe_low: assert property (p_safe_low)
      else $error("switch flagged with input held low");

   c_to_osc:  cover property (@(posedge sys_clk) $rose(clk_sel) ##[1:20] mclk_tick);
   c_lp_mod:  cover property (@(posedge sys_clk) power_mode_select == PWR_LP && mod_tick);
   c_testpos: cover property (@(posedge sys_clk) $rose(test_pos_enable));
   c_conv:    cover property (@(posedge sys_clk) $rose(conv_enable));

endmodule
`default_nettype wire

// File: acs_pkg.sv
// Shared constants, types and helpers for the converter clock and front-end control
package acs_pkg;

   // ==========================================================
   // Timing
   localparam int SYS_CLK_KHZ    = 40000;
   localparam int OSC_KHZ        = 8192;
   localparam int REF_SETTLE_US  = 20;
   localparam int REF_SETTLE_CYC = (REF_SETTLE_US * SYS_CLK_KHZ + 999) / 1000;
   localparam int NUM_CH         = 2;
   localparam int ACC_W          = 17;

   // ==========================================================
   // Register offsets
   localparam logic [7:0] ADDR_CLOCK   = 8'h00;
   localparam logic [7:0] ADDR_CH_CFG0 = 8'h04;
   localparam logic [7:0] CH_CFG_STEP  = 8'h04;
   localparam logic [7:0] ADDR_GAIN    = 8'h10;
   localparam logic [7:0] ADDR_STATUS  = 8'h14;

   // ==========================================================
   // Field positions
   localparam int CLK_SEL_BIT   = 0;
   localparam int PWR_LSB       = 1;
   localparam int STANDBY_BIT   = 3;
   localparam int MUX_LSB       = 0;
   localparam int GAIN_STRIDE   = 4;
   localparam int ST_REF_BIT    = 0;
   localparam int ST_OSC_BIT    = 1;
   localparam int ST_SEEN_BIT   = 2;
   localparam int ST_UNSAFE_BIT = 3;

   // ==========================================================
   // Types and codes
   typedef logic [1:0] acs_mux_t;
   typedef logic [2:0] acs_gain_t;
   typedef logic [1:0] acs_pwr_t;

   localparam acs_mux_t MUX_PINS     = 2'h0;
   localparam acs_mux_t MUX_GND      = 2'h1;
   localparam acs_mux_t MUX_TEST_POS = 2'h2;
   localparam acs_mux_t MUX_TEST_NEG = 2'h3;
   localparam acs_pwr_t PWR_HR       = 2'h0;
   localparam acs_pwr_t PWR_LP       = 2'h1;
   localparam acs_pwr_t PWR_VLP      = 2'h2;

   // ==========================================================
   // Reset values
   localparam logic      CLK_SEL_RST = 1'b0;
   localparam acs_pwr_t  PWR_RST     = PWR_HR;
   localparam logic      STANDBY_RST = 1'b0;
   localparam acs_mux_t  MUX_RST     = MUX_PINS;
   localparam acs_gain_t GAIN_RST    = 3'h0;

   // Oscillator ticks per main clock tick, minus one
   function automatic logic [1:0] acs_div_limit(input acs_pwr_t p);
      unique case (p)
         PWR_HR:  return 2'h0;
         PWR_LP:  return 2'h1;
         default: return 2'h3;
      endcase
   endfunction

   function automatic logic [3:0] acs_route(input acs_mux_t m);
      return 4'h1 << m;
   endfunction

endpackage

// File: acs_clk_if.sv
// Tick and control wires between the clock control core and its dividers
`timescale 1ns/1ps
`default_nettype none
interface acs_clk_if;
   logic               osc_en;
   acs_pkg::acs_pwr_t  power_mode_select;
   logic               run;
   logic               osc_mclk_tick;
   logic               mclk_pulse;
   logic               mod_tick;

   modport ctrl (output osc_en, power_mode_select, run, mclk_pulse,
                 input  osc_mclk_tick, mod_tick);
   modport osc  (input osc_en, power_mode_select, output osc_mclk_tick);
   modport modg (input mclk_pulse, run, output mod_tick);
endinterface
`default_nettype wire

// File: acs_osc_div.sv
// Internal oscillator tick source with power-mode divider
`timescale 1ns/1ps
`default_nettype none
module acs_osc_div (
   input  wire logic sys_clk,
   input  wire logic reset_n,
   acs_clk_if.osc    bus
);
   import acs_pkg::*;

   logic [ACC_W-1:0] acc;
   logic [ACC_W-1:0] next_acc;
   logic [1:0]       div;
   logic [1:0]       next_div;
   logic             tick;
   logic             next_tick;
   logic [ACC_W-1:0] sum;
   logic             osc_edge;

   // ==========================================================
   // Fractional accumulator keeps the average oscillator rate exact
   always_comb begin
      next_acc  = acc;
      next_div  = div;
      next_tick = 1'b0;
      osc_edge  = 1'b0;
      sum       = acc + ACC_W'(OSC_KHZ);
      if (!bus.osc_en) begin
         next_acc = '0;
         next_div = 2'h0;
      end else begin
         if (sum >= ACC_W'(SYS_CLK_KHZ)) begin
            next_acc = sum - ACC_W'(SYS_CLK_KHZ);
            osc_edge = 1'b1;
         end else begin
            next_acc = sum;
         end
         if (osc_edge) begin
            if (div >= acs_div_limit(bus.power_mode_select)) begin
               next_div  = 2'h0;
               next_tick = 1'b1;
            end else begin
               next_div = div + 2'h1;
            end
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         acc  <= '0;
         div  <= 2'h0;
         tick <= 1'b0;
      end else begin
         acc  <= next_acc;
         div  <= next_div;
         tick <= next_tick;
      end
   end

   assign bus.osc_mclk_tick = tick;

   // ==========================================================
   // Checks
   property p_hr_gap;
      @(posedge sys_clk) disable iff (!reset_n)
      tick |=> !tick [*3];
   endproperty
   a_hr_gap: assert property (p_hr_gap)
      else $error("oscillator ticks closer than 8.192 MHz");

   property p_lp_gap;
      @(posedge sys_clk) disable iff (!reset_n)
      tick && bus.power_mode_select == PWR_LP && $stable(bus.power_mode_select) |=> !tick [*8];
   endproperty
   a_lp_gap: assert property (p_lp_gap)
      else $error("reduced power tick too fast");

endmodule
`default_nettype wire

// File: acs_mod_div.sv
// Modulator tick at half the main clock tick rate
`timescale 1ns/1ps
`default_nettype none
module acs_mod_div (
   input  wire logic sys_clk,
   input  wire logic reset_n,
   acs_clk_if.modg   bus
);
   import acs_pkg::*;

   logic phase;
   logic next_phase;
   logic tick;
   logic next_tick;
   logic pulses;

   // ==========================================================
   // Phase restarts in standby so resume is deterministic
   always_comb begin
      next_phase = phase;
      next_tick  = 1'b0;
      if (!bus.run) begin
         next_phase = 1'b0;
      end else if (bus.mclk_pulse) begin
         next_phase = ~phase;
         next_tick  = phase;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         phase <= 1'b0;
         tick  <= 1'b0;
      end else begin
         phase <= next_phase;
         tick  <= next_tick;
      end
   end

   assign bus.mod_tick = tick;

   // ==========================================================
   // Checks
   always_ff @(posedge sys_clk) begin
      if (!reset_n || !bus.run || tick) begin
         pulses <= 1'b0;
      end else if (bus.mclk_pulse) begin
         pulses <= 1'b1;
      end
   end

   property p_half_rate;
      @(posedge sys_clk) disable iff (!reset_n)
      bus.run && bus.mclk_pulse && pulses |=> tick;
   endproperty
   a_half_rate: assert property (p_half_rate)
      else $error("modulator tick missing after two main ticks");

endmodule
`default_nettype wire

// File: acs_clock_ctrl_test.sv
// Self-checking bench for the clock and front-end control block
`timescale 1ns/1ps
`default_nettype none
module acs_clock_ctrl_test;
   import acs_pkg::*;
   localparam int REF = 10;
   logic        sys_clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        cyc     = 1'b0;
   logic        we      = 1'b0;
   logic        pin     = 1'b0;
   logic        ext_run = 1'b0;
   logic [7:0]  adr     = 8'h00;
   logic [31:0] wdat    = 32'h0;
   logic [31:0] rd, dat_o;
   logic        ack, osc_en, mclk, modt, conv, tpos, tneg;
   acs_pwr_t    bias;
   logic [7:0]  route;
   logic [5:0]  gain;
   acs_mux_t    mx [2];
   int          n_fail = 0, checked = 0, n_mclk = 0, n_mod = 0, n_edge = 0;
   int          ph = 0, m0, d0, e0, c, m, g;

   acs_clock_ctrl #(.REF_CYC(REF)) acs_clock_ctrl_i (
      .sys_clk(sys_clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .external_clock_input(pin),
      .osc_enable(osc_en), .mclk_tick(mclk), .mod_tick(modt),
      .conv_enable(conv), .bias_level(bias), .channel_route(route),
      .channel_gain_code(gain), .test_pos_enable(tpos),
      .test_neg_enable(tneg));

   always #12.5 sys_clk = ~sys_clk;

   task automatic finish_test;
      if (n_fail == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
      checked++;
      if (s !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic near(string nm, int e, int s, int tol);
      checked++;
      if (s > e + tol || s < e - tol) begin
         n_fail++;
         $display("[ERR] %s expected %0d seen %0d", nm, e, s);
      end
   endtask

   // ==========================================================
   // Classic single Wishbone cycle, held until ack is seen
   task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
      int i;
      @(posedge sys_clk);
      cyc  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      for (i = 0; i < 20; i++) begin
         @(posedge sys_clk);
         if (ack === 1'b1)
            break;
      end
      if (i == 20) begin
         n_fail++;
         $display("[ERR] ack expected 1 seen 0");
         finish_test();
      end
      rd = dat_o;
      cyc <= 1'b0;
   endtask

   task automatic idle(int n);
      repeat (n) @(negedge sys_clk);
   endtask

   function automatic int exp_ticks(int p, int n);
      return n * OSC_KHZ / SYS_CLK_KHZ / ((p == 0) ? 1 : (p == 1) ? 2 : 4);
   endfunction

   // ==========================================================
   // Tick counters and external pin at a period of six cycles
   always @(posedge sys_clk) begin
      if (mclk === 1'b1)
         n_mclk <= n_mclk + 1;
      if (modt === 1'b1)
         n_mod <= n_mod + 1;
      // modulator tick only with a main tick
      if (modt === 1'b1 && mclk !== 1'b1) begin
         n_fail <= n_fail + 1;
         $display("[ERR] mod_tick expected 0 seen 1");
      end
      if (ext_run) begin
         ph <= (ph == 2) ? 0 : ph + 1;
         if (ph == 2) begin
            pin <= ~pin;
            if (!pin)
               n_edge <= n_edge + 1;
         end
      end
   end

   initial begin
      void'($urandom(17));
      mx = '{MUX_RST, MUX_RST};
      repeat (5) @(posedge sys_clk);
      reset_n <= 1'b1;
      wb(0, ADDR_CLOCK, 0);
      chk("clock", 32'h0, rd);
      chk("osc_en", 0, osc_en);
      idle(REF / 2);
      chk("conv", 0, conv);
      idle(REF);
      chk("conv", 1, conv);
      chk("route", 8'h11, route);
      // Corner sweep of all sources, then random mixes
      for (int i = 0; i < 16; i++) begin
         c = (i < 8) ? i / 4 : $urandom % 2;
         m = (i < 8) ? i % 4 : $urandom % 4;
         g = $urandom % 64;
         mx[c] = m[1:0];
         wb(1, ADDR_CH_CFG0 + CH_CFG_STEP * c[7:0], m);
         wb(1, ADDR_GAIN, {g[5:3], 1'b0, g[2:0]});
         idle(2);
         chk("route", {4'h1 << mx[1], 4'h1 << mx[0]}, route);
         chk("tpos", mx[0] == 2 || mx[1] == 2, tpos);
         chk("tneg", mx[0] == 3 || mx[1] == 3, tneg);
         chk("gain", g, gain);
      end
      wb(1, 8'h40, 32'hffff_ffff);
      wb(0, 8'h40, 0);
      chk("unmapped", 0, rd);
      // Leaving a held-low pin needs no standby
      wb(1, ADDR_CLOCK, 1);
      idle(2);
      chk("osc_en", 1, osc_en);
      wb(0, ADDR_STATUS, 0);
      chk("status", 32'h3, rd);
      for (int p = 0; p < 4; p++) begin
         if (p > 0)
            wb(1, ADDR_CLOCK, 9 | ((p - 1) << 1));
         wb(1, ADDR_CLOCK, 9 | (p << 1));
         // Let the last pre-standby tick drain
         idle(3);
         m0 = n_mclk;
         idle(47);
         near("standby_ticks", 0, n_mclk - m0, 0);
         chk("conv", 0, conv);
         wb(1, ADDR_CLOCK, 1 | (p << 1));
         idle(20);
         chk("bias", (p == 3) ? 2 : p, bias);
         m0 = n_mclk;
         d0 = n_mod;
         idle(4000);
         near("mclk", exp_ticks(p, 4000), n_mclk - m0, 2);
         near("mod", (n_mclk - m0) / 2, n_mod - d0, 1);
      end
      wb(1, ADDR_CLOCK, 15);
      wb(1, ADDR_CLOCK, 9);
      wb(1, ADDR_CLOCK, 8);
      wb(1, ADDR_CLOCK, 0);
      ext_run <= 1'b1;
      idle(20);
      chk("osc_en", 0, osc_en);
      m0 = n_mclk;
      d0 = n_mod;
      e0 = n_edge;
      idle(600);
      near("ext_mclk", n_edge - e0, n_mclk - m0, 1);
      near("ext_mod", (n_mclk - m0) / 2, n_mod - d0, 1);
      // Running pin switched without standby is flagged
      wb(1, ADDR_CLOCK, 1);
      wb(0, ADDR_STATUS, 0);
      chk("unsafe", 32'h1, {31'h0, rd[3]});
      chk("seen", 32'h1, {31'h0, rd[2]});
      wb(1, ADDR_STATUS, 8);
      wb(0, ADDR_STATUS, 0);
      chk("unsafe", 32'h0, {31'h0, rd[3]});
      finish_test();
   end
endmodule
`default_nettype wire
